//--- verif/scc_dac_model.sv
// Purpose: Output DAC standing at the far side of the code FIFO
// Assumes: Takes a code at an edge with valid and ready
// Notes: Accepts every other cycle; stall holds ready low
`timescale 1ns/1ps
`default_nettype none

module scc_dac_model (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Reset, active high
    input wire logic stall, // Bench-driven stall
    input wire logic dac_valid, // Code offered
    input wire logic [15:0] dac_code, // Code
    output logic dac_ready, // Code taken
    output logic got, // Code taken at last edge
    output logic [15:0] got_code // That code
);
    logic slow_r;

    // Ready on alternate cycles gives prompt and slow answers
    assign dac_ready = !stall && !slow_r;

    // Record each taken code
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slow_r <= 1'b0;
            got <= 1'b0;
            got_code <= 16'h0000;
        end else begin
            slow_r <= ~slow_r;
            got <= dac_valid && dac_ready;
            got_code <= dac_code;
        end
    end
endmodule : scc_dac_model

`default_nettype wire

//--- verif/scc_top_chk.sv
// Purpose: Port-level checks on the compensation datapath
// Assumes: One clock, sys_rst async active high
// Notes: Bound to every scc_top instance
`timescale 1ns/1ps
`default_nettype none

module scc_top_chk (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Reset, active high
    input wire logic adc_valid, // Pair offered
    input wire logic adc_ready, // Sequencer idle
    input wire scc_pkg::scc_limit_cfg_t limit_cfg, // Clamp and normal limits
    input wire scc_pkg::scc_filt_cfg_t filt_cfg, // Filter coefficients
    input wire logic [23:0] compensated_result, // Unfiltered result
    input wire logic [23:0] filtered_result, // Filter output
    input wire logic below_normal, // Under normal span
    input wire logic above_normal, // Over normal span
    input wire logic dac_valid, // DAC code offered
    input wire logic dac_ready, // DAC takes code
    input wire logic [15:0] dac_code // DAC code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic take;
    // Take edge of a pair
    assign take = adc_valid && adc_ready;

    a_busy_start: assert property (take |=> !adc_ready [*8])
        else $error("ready came back too early");
    a_busy_end: assert property (take |-> ##22 !adc_ready)
        else $error("ready back before pass end");
    a_ready_return: assert property (take |-> ##[23:1000] adc_ready)
        else $error("ready never came back");
    a_result_hold: assert property (take |=>
        ($stable(compensated_result) && $stable(filtered_result)) [*8])
        else $error("results moved early in a pass");
    a_clamp_range: assert property ($rose(adc_ready) |->
        $signed(compensated_result) >= limit_cfg.low_clamp
        && $signed(compensated_result) <= limit_cfg.high_clamp)
        else $error("result outside clamp limits");
    a_flag_below: assert property ($rose(adc_ready) |->
        below_normal == ($signed(compensated_result) < limit_cfg.normal_low))
        else $error("below flag wrong");
    a_flag_above: assert property ($rose(adc_ready) |->
        above_normal == ($signed(compensated_result) > limit_cfg.normal_high))
        else $error("above flag wrong");
    a_filter_bypass: assert property ($rose(adc_ready) && filt_cfg.a0 == 16'sh0000 |->
        filtered_result == compensated_result)
        else $error("bypass altered value");
    a_dac_hold: assert property (dac_valid && !dac_ready |=>
        dac_valid && $stable(dac_code))
        else $error("DAC code not held");
endmodule : scc_top_chk

bind scc_top scc_top_chk i_scc_top_chk (.clk(clk), .sys_rst(sys_rst), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .limit_cfg(limit_cfg), .filt_cfg(filt_cfg),
    .compensated_result(compensated_result), .filtered_result(filtered_result),
    .below_normal(below_normal), .above_normal(above_normal), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .dac_code(dac_code));

`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the compensation datapath
// Assumes: Inputs change on the falling edge of clk
// Notes: Expected values come from bench functions
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, adc_valid = 1'b0, ord = 1'b0, mode = 1'b1, stall = 1'b0;
    logic coef_wr_en = 1'b0;
    logic [3:0] coef_wr_idx = 4'h0;
    logic [23:0] p_adc = 24'h000000, t_adc = 24'h000000, coef_wr_data = 24'h000000;
    scc_pkg::scc_corr_cfg_t pcfg = '0, tcfg = '0;
    scc_pkg::scc_limit_cfg_t lim = '0;
    scc_pkg::scc_filt_cfg_t filt = '0;
    logic adc_ready, below, above, dac_valid, dac_ready, got;
    logic [23:0] comp, filt_out;
    logic [15:0] dac_code, got_code;
    int error_cnt = 0, n_checks = 0, cyc = 0, wt;
    logic [31:0] rnd = 32'h00000030;
    longint h0, g0, n0, w1, w2;
    logic [15:0] expq[$];

    scc_top i_scc_top (.clk(clk), .sys_rst(sys_rst), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .pressure_adc(p_adc), .temperature_adc(t_adc), .offset_order(ord), .pressure_cfg(pcfg),
        .temperature_cfg(tcfg), .limit_cfg(lim), .filt_cfg(filt), .mode_24bit(mode),
        .coef_wr_en(coef_wr_en), .coef_wr_idx(coef_wr_idx), .coef_wr_data(coef_wr_data),
        .compensated_result(comp), .filtered_result(filt_out), .below_normal(below),
        .above_normal(above), .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_code(dac_code));
    scc_dac_model i_scc_dac_model (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .dac_valid(dac_valid), .dac_code(dac_code), .dac_ready(dac_ready), .got(got),
        .got_code(got_code));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic longint sat(input longint v);
        return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
    endfunction : sat
    // Corrected value in either order
    function automatic longint corr(input logic [23:0] adc, input scc_pkg::scc_corr_cfg_t c);
        longint g, o, a;
        g = longint'($signed({c.gain_high_byte, c.gain_low_byte}));
        o = longint'($signed({c.offset_high_byte, c.offset_low_byte}));
        a = longint'($signed(adc));
        return sat(ord ? (g * (a + o)) >>> 14 : ((g * a) >>> 14) + o);
    endfunction : corr
    // Polynomial, P^0 doubles h0, then clamp
    function automatic longint comp_exp(input longint p);
        longint v;
        v = 2 * h0 + ((g0 * p) >>> 22) + ((n0 * ((p * p) >>> 23)) >>> 22);
        v = v < lim.low_clamp ? lim.low_clamp : v;
        return v > lim.high_clamp ? lim.high_clamp : v;
    endfunction : comp_exp

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    // Offer one pair, check every result
    task automatic sample(input logic [23:0] p, input logic [23:0] t);
        longint x, y, wx;
        for (wt = 0; wt < 50 && !adc_ready; wt++) @(negedge clk);
        adc_valid = 1'b1;
        p_adc = p;
        t_adc = t;
        @(negedge clk);
        adc_valid = 1'b0;
        p_adc = ~p;
        t_adc = ~t;
        for (wt = 0; wt < 2000 && !adc_ready; wt++) begin
            if (wt == 100) stall = 1'b0;
            @(negedge clk);
        end
        x = comp_exp(corr(p, pcfg));
        chk("compensated", comp, x[23:0]);
        chk("below", below, x < lim.normal_low);
        chk("above", above, x > lim.normal_high);
        if (filt.a0 == 16'sh0000) y = x;
        else begin
            wx = sat((filt.a0 * x + filt.a1 * w1 + filt.a2 * w2) >>> 14);
            y = sat((filt.b0 * wx + filt.b1 * w1 + filt.b2 * w2) >>> 14);
            w2 = w1;
            w1 = wx;
        end
        chk("filtered", filt_out, y[23:0]);
        expq.push_back(16'(y >>> (mode ? 10 : 2)));
    endtask : sample

    // Reset, load, random pairs, drain
    task automatic run(input int k);
        int i;
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        ord = k[0];
        mode = !k[0];
        rnd = lfsr(rnd);
        pcfg = {k ? 16'h6000 : 16'h4000, rnd[15:0]};
        tcfg = {16'h4000, rnd[31:16]};
        lim = k ? {-24'sh200000, 24'sh300000, -24'sh100000, 24'sh100000}
            : {24'sh800000, 24'sh7fffff, -24'sh100000, 24'sh100000};
        filt = k ? {16'h4000, 16'h2000, 16'h1000, 16'h2000, 16'h1000, 16'h1000} : '0;
        h0 = k ? -64'sh140000 : 64'sh0c0000;
        g0 = k ? 64'sh0600000 : 64'sh0400000;
        n0 = k ? 64'sh0100000 : 64'sh0;
        sys_rst = 1'b0;
        for (i = 0; i < 16; i++) begin
            coef_wr_en = 1'b1;
            coef_wr_idx = 4'(i);
            coef_wr_data = i == 0 ? 24'(h0) : (i == 4 ? 24'(g0) : (i == 8 ? 24'(n0) : 24'h0));
            @(negedge clk);
        end
        coef_wr_en = 1'b0;
        w1 = 0;
        w2 = 0;
        stall = k[0];
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            sample(i == 0 ? 24'h7fffff : (i == 1 ? 24'h800000 : {{4{rnd[19]}}, rnd[19:0]}),
                rnd[31:8]);
            if (k[0]) chk("fifo stall", wt > 99, i == 8);
        end
        for (i = 0; i < 500 && expq.size() > 0; i++) @(negedge clk);
        chk("left in fifo", 24'(expq.size()), 24'h000000);
    endtask : run

    // Taken codes match the oldest expected
    always @(negedge clk) begin
        if (got) begin
            if (expq.size() == 0) chk("dac extra", 24'h000001, 24'h000000);
            else chk("dac code", {8'h00, got_code}, {8'h00, expq.pop_front()});
        end
    end

    // Clock generator
    initial begin
        forever #5 clk = ~clk;
    end

    // Cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        run(0);
        run(1);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire

//--- verilog/scc_coef_mem.sv
// Purpose: Sixteen-entry store for compensation coefficients
// Assumes: Loaded from nonvolatile configuration through the write port
// Notes:   Read data is registered, one cycle after the address
`default_nettype none
`timescale 1ns/1ps

module scc_coef_mem (
    input wire logic clk, // System clock
    input wire logic wr_en, // Write strobe
    input wire logic [scc_pkg::COEF_AW-1:0] wr_idx, // Write index
    input wire logic [scc_pkg::COEF_W-1:0] wr_data, // Write data
    input wire logic [scc_pkg::COEF_AW-1:0] rd_idx, // Read index
    output logic [scc_pkg::COEF_W-1:0] rd_data // Registered read data
);

    logic [scc_pkg::COEF_W-1:0] mem [scc_pkg::COEF_N];

    // Write port and registered read port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end

endmodule : scc_coef_mem

`default_nettype wire

//--- verilog/scc_fifo.sv
// Purpose: Small synchronous FIFO between the datapath and the DAC
// Assumes: One clock, valid/ready on both sides
// Notes:   Full and empty follow the occupancy count exactly
`default_nettype none
`timescale 1ns/1ps

module scc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Not empty
    input wire logic out_ready, // Read accept
    output logic [WIDTH-1:0] out_data // Head entry
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    // Handshakes from occupancy
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r];

    // Pointer and count next values
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push) begin
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
        end
        if (push && !pop) begin
            count_nxt = count_r + (AW+1)'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - (AW+1)'(1);
        end
    end

    // Pointer and count registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

endmodule : scc_fifo

`default_nettype wire

//--- verilog/scc_pkg.sv
// Purpose: Shared constants, carriers and states for the compensation datapath
// Assumes: All arithmetic is signed two's complement
// Notes:   Fixed-point positions live here
`default_nettype none

package scc_pkg;

    // Data widths
    localparam int ADC_W = 24;
    localparam int COEF_W = 24;
    localparam int COEF_N = 16;
    localparam int COEF_AW = 4;
    localparam int POW_W = 25;
    localparam int ACC_W = 40;
    localparam int DAC_W = 16;
    localparam int FIFO_DEPTH = 8;

    // Fixed-point positions
    localparam int GAIN_FRAC = 14;
    localparam int COEF_FRAC = 22;
    localparam int POW_FRAC = 23;
    localparam int FILT_FRAC = 14;

    // Output scaling: divide by 1024 or by 4
    localparam int DAC_SHIFT_24 = 10;
    localparam int DAC_SHIFT_16 = 2;

    // Offset order select codes
    localparam logic ORDER_GAIN_FIRST = 1'b0;
    localparam logic ORDER_OFFSET_FIRST = 1'b1;

    // Power zero in the Q23 power domain
    localparam logic signed [POW_W-1:0] POW_ONE = 25'sh0800000;

    // Filter disable code for a0
    localparam logic signed [15:0] FILT_A0_OFF = 16'sh0000;

    // Reset values
    localparam logic signed [ADC_W-1:0] DATA_RST = 24'sh000000;
    localparam logic signed [ACC_W-1:0] ACC_RST = 40'sh0000000000;

    // Gain and offset bytes for one channel
    typedef struct packed {
        logic [7:0] gain_high_byte;
        logic [7:0] gain_low_byte;
        logic [7:0] offset_high_byte;
        logic [7:0] offset_low_byte;
    } scc_corr_cfg_t;

    // Second-order filter coefficients, Q14
    typedef struct packed {
        logic signed [15:0] a0;
        logic signed [15:0] a1;
        logic signed [15:0] a2;
        logic signed [15:0] b0;
        logic signed [15:0] b1;
        logic signed [15:0] b2;
    } scc_filt_cfg_t;

    // Clamp and normal-range limits
    typedef struct packed {
        logic signed [23:0] low_clamp;
        logic signed [23:0] high_clamp;
        logic signed [23:0] normal_low;
        logic signed [23:0] normal_high;
    } scc_limit_cfg_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CORR = 3'h1,
        ST_POW2 = 3'h2,
        ST_POW3 = 3'h3,
        ST_MAC = 3'h4,
        ST_CLAMP = 3'h5,
        ST_FILT = 3'h6,
        ST_PUSH = 3'h7
    } scc_state_t;

endpackage : scc_pkg

`default_nettype wire

//--- verilog/scc_top.sv
// Purpose: Gain/offset correction, cubic compensation, clamp, IIR and DAC scaling
// Assumes: ADC samples arrive from logic on the same clock; config is static
// Notes:   One sample pair is processed at a time; DAC codes pass an 8-deep FIFO
//
// Contract
// RULE1 - Select 0: corrected value is gain times ADC plus offset, per channel.
// RULE2 - Select 1: offset is added to ADC first, then multiplied by gain.
// RULE3 - Gain and offset each built from high and low configuration bytes.
// RULE4 - Result sums pressure powers 0..3 times cubic in temperature, sixteen coefficients.
// RULE5 - Unfiltered compensated result is available for external readback.
// RULE6 - DAC value is result divided by 1024 (24-bit) or 4 (16-bit).
// RULE7 - Stored coefficients are fixed-point values scaled by two to the 22.
// RULE8 - Configuring party zeroes all but constant and linear terms to bypass compensation.
// RULE9 - Compensation output is clamped between programmable low and high limits.
// RULE10 - Normal-range low and high values are held and define the normal span.
// RULE11 - In current-loop mode the low clamp must exceed the device's own current.
// RULE12 - Filter state is a0 times input plus a1, a2 times earlier states.
// RULE13 - Filter output is b0, b1, b2 times current and two earlier states.
// RULE14 - Configuring party writes a0 as zero to disable filtering.
// RULE15 - Whole datapath runs once per sample pair; filter history updates only then.
// RULE16 - Signed arithmetic with wide intermediates, no overflow before the clamp.
`default_nettype none
`timescale 1ns/1ps

module scc_top (
    input wire logic clk, // System clock, 100 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic adc_valid, // New pressure/temperature pair offered
    output logic adc_ready, // Datapath idle, pair taken when valid
    input wire logic [23:0] pressure_adc, // Pressure ADC result, signed
    input wire logic [23:0] temperature_adc, // Temperature ADC result, signed
    input wire logic offset_order, // 0: gain then offset, 1: offset then gain
    input wire scc_pkg::scc_corr_cfg_t pressure_cfg, // Pressure gain/offset bytes
    input wire scc_pkg::scc_corr_cfg_t temperature_cfg, // Temperature gain/offset bytes
    input wire scc_pkg::scc_limit_cfg_t limit_cfg, // Clamp and normal limits
    input wire scc_pkg::scc_filt_cfg_t filt_cfg, // IIR coefficients
    input wire logic mode_24bit, // 1: 24-bit mode, 0: 16-bit mode
    input wire logic coef_wr_en, // Coefficient load strobe
    input wire logic [3:0] coef_wr_idx, // Coefficient index, p power*4 + t power
    input wire logic [23:0] coef_wr_data, // Coefficient value, Q22
    output logic [23:0] compensated_result, // Unfiltered clamped result
    output logic [23:0] filtered_result, // Filter output
    output logic below_normal, // Last result under normal low
    output logic above_normal, // Last result over normal high
    output logic dac_valid, // DAC code available
    input wire logic dac_ready, // DAC takes code
    output logic [15:0] dac_code // Scaled DAC code
);

    // Saturate a wide signed value into 24 bits
    function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
        logic signed [23:0] r;
        if (v > 48'sh0000007fffff) begin
            r = 24'sh7fffff;
        end else if (v < -48'sh000000800000) begin
            r = -24'sh800000;
        end else begin
            r = v[23:0];
        end
        return r;
    endfunction : sat24

    // Digital gain and offset for one channel
    function automatic logic signed [23:0] correct(input logic signed [23:0] adc,
                                                   input scc_pkg::scc_corr_cfg_t cfg,
                                                   input logic order);
        logic signed [15:0] gain;
        logic signed [15:0] off;
        logic signed [47:0] prod;
        logic signed [47:0] v;
        gain = {cfg.gain_high_byte, cfg.gain_low_byte}; // RULE3
        off = {cfg.offset_high_byte, cfg.offset_low_byte}; // RULE3
        if (order == scc_pkg::ORDER_OFFSET_FIRST) begin
            prod = 48'(gain) * (48'(adc) + 48'(off)); // RULE2
            v = prod >>> scc_pkg::GAIN_FRAC;
        end else begin
            prod = 48'(gain) * 48'(adc); // RULE1
            v = (prod >>> scc_pkg::GAIN_FRAC) + 48'(off); // RULE1
        end
        return sat24(v); // RULE16
    endfunction : correct

    // Product of two Q23 powers
    function automatic logic signed [24:0] mul_q23(input logic signed [24:0] a,
                                                   input logic signed [24:0] b);
        logic signed [49:0] m;
        m = (50'(a) * 50'(b)) >>> scc_pkg::POW_FRAC;
        return m[24:0];
    endfunction : mul_q23

    scc_pkg::scc_state_t state_r;
    scc_pkg::scc_state_t state_nxt;
    logic [3:0] idx_r;
    logic [3:0] idx_nxt;
    logic signed [24:0] ppow_r [4];
    logic signed [24:0] ppow_nxt [4];
    logic signed [24:0] tpow_r [4];
    logic signed [24:0] tpow_nxt [4];
    logic signed [39:0] acc_r;
    logic signed [39:0] acc_nxt;
    logic signed [23:0] data_r;
    logic signed [23:0] data_nxt;
    logic signed [23:0] w1_r;
    logic signed [23:0] w1_nxt;
    logic signed [23:0] w2_r;
    logic signed [23:0] w2_nxt;
    logic signed [23:0] filt_r;
    logic signed [23:0] filt_nxt;
    logic below_r;
    logic below_nxt;
    logic above_r;
    logic above_nxt;
    logic signed [23:0] p_raw_r;
    logic signed [23:0] t_raw_r;
    logic signed [23:0] p_raw_nxt;
    logic signed [23:0] t_raw_nxt;

    logic [23:0] coef_rdata;
    logic [3:0] coef_rd_idx;
    logic fifo_in_ready;
    logic signed [51:0] term_m1;
    logic signed [26:0] term_s1;
    logic signed [55:0] term_m2;
    logic signed [55:0] term;
    logic signed [47:0] w_sum;
    logic signed [23:0] w_new;
    logic signed [47:0] y_sum;
    logic signed [47:0] shifted;

    // Pair accepted only when idle
    assign adc_ready = (state_r == scc_pkg::ST_IDLE); // RULE15

    // Read ahead: entry 0 before the loop, next entry during it
    assign coef_rd_idx = (state_r == scc_pkg::ST_MAC) ? idx_r + 4'h1 : 4'h0;

    scc_coef_mem u_coef_mem (
        .clk(clk),
        .wr_en(coef_wr_en),
        .wr_idx(coef_wr_idx),
        .wr_data(coef_wr_data),
        .rd_idx(coef_rd_idx),
        .rd_data(coef_rdata)
    );

    // One coefficient term: c(Q22) * T^j(Q23) * P^i(Q23), index = i*4 + j
    always_comb begin
        term_m1 = 52'($signed(coef_rdata)) * 52'(tpow_r[idx_r[1:0]]); // RULE4
        term_s1 = 27'(term_m1 >>> scc_pkg::POW_FRAC);
        term_m2 = 56'(term_s1) * 56'(ppow_r[idx_r[3:2]]); // RULE4
        term = term_m2 >>> scc_pkg::COEF_FRAC; // RULE7
    end

    // Filter arithmetic, Q14 coefficients
    always_comb begin
        w_sum = 48'(filt_cfg.a0) * 48'(data_r) + 48'(filt_cfg.a1) * 48'(w1_r)
              + 48'(filt_cfg.a2) * 48'(w2_r); // RULE12
        w_new = sat24(w_sum >>> scc_pkg::FILT_FRAC); // RULE16
        y_sum = 48'(filt_cfg.b0) * 48'(w_new) + 48'(filt_cfg.b1) * 48'(w1_r)
              + 48'(filt_cfg.b2) * 48'(w2_r); // RULE13
    end

    // Sequencer next state and datapath next values
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        ppow_nxt = ppow_r;
        tpow_nxt = tpow_r;
        acc_nxt = acc_r;
        data_nxt = data_r;
        w1_nxt = w1_r;
        w2_nxt = w2_r;
        filt_nxt = filt_r;
        below_nxt = below_r;
        above_nxt = above_r;
        p_raw_nxt = p_raw_r;
        t_raw_nxt = t_raw_r;
        shifted = 48'(filt_r);
        case (state_r)
            scc_pkg::ST_IDLE: begin
                if (adc_valid) begin
                    p_raw_nxt = pressure_adc; // RULE15
                    t_raw_nxt = temperature_adc; // RULE15
                    state_nxt = scc_pkg::ST_CORR;
                end
            end
            scc_pkg::ST_CORR: begin
                ppow_nxt[0] = scc_pkg::POW_ONE;
                tpow_nxt[0] = scc_pkg::POW_ONE;
                ppow_nxt[1] = 25'(correct(p_raw_r, pressure_cfg, offset_order));
                tpow_nxt[1] = 25'(correct(t_raw_r, temperature_cfg, offset_order));
                state_nxt = scc_pkg::ST_POW2;
            end
            scc_pkg::ST_POW2: begin
                ppow_nxt[2] = mul_q23(ppow_r[1], ppow_r[1]); // RULE4
                tpow_nxt[2] = mul_q23(tpow_r[1], tpow_r[1]); // RULE4
                state_nxt = scc_pkg::ST_POW3;
            end
            scc_pkg::ST_POW3: begin
                ppow_nxt[3] = mul_q23(ppow_r[2], ppow_r[1]); // RULE4
                tpow_nxt[3] = mul_q23(tpow_r[2], tpow_r[1]); // RULE4
                acc_nxt = scc_pkg::ACC_RST;
                idx_nxt = 4'h0;
                state_nxt = scc_pkg::ST_MAC;
            end
            scc_pkg::ST_MAC: begin
                acc_nxt = acc_r + term[39:0]; // RULE16
                idx_nxt = idx_r + 4'h1;
                if (idx_r == 4'hf) begin
                    state_nxt = scc_pkg::ST_CLAMP;
                end
            end
            scc_pkg::ST_CLAMP: begin
                if (acc_r < 40'(limit_cfg.low_clamp)) begin
                    data_nxt = limit_cfg.low_clamp; // RULE9
                end else if (acc_r > 40'(limit_cfg.high_clamp)) begin
                    data_nxt = limit_cfg.high_clamp; // RULE9
                end else begin
                    data_nxt = acc_r[23:0];
                end
                state_nxt = scc_pkg::ST_FILT;
            end
            scc_pkg::ST_FILT: begin
                below_nxt = (data_r < limit_cfg.normal_low); // RULE10
                above_nxt = (data_r > limit_cfg.normal_high); // RULE10
                if (filt_cfg.a0 == scc_pkg::FILT_A0_OFF) begin
                    filt_nxt = data_r; // RULE14
                    w1_nxt = data_r;
                end else begin
                    filt_nxt = sat24(y_sum >>> scc_pkg::FILT_FRAC); // RULE13
                    w1_nxt = w_new; // RULE12
                end
                w2_nxt = w1_r; // RULE15
                state_nxt = scc_pkg::ST_PUSH;
            end
            scc_pkg::ST_PUSH: begin
                shifted = 48'(filt_r) >>> (mode_24bit ? scc_pkg::DAC_SHIFT_24
                                                      : scc_pkg::DAC_SHIFT_16); // RULE6
                if (fifo_in_ready) begin
                    state_nxt = scc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = scc_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer and datapath registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= scc_pkg::ST_IDLE;
            idx_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                ppow_r[i] <= 25'sh0000000;
                tpow_r[i] <= 25'sh0000000;
            end
            acc_r <= scc_pkg::ACC_RST;
            data_r <= scc_pkg::DATA_RST;
            w1_r <= scc_pkg::DATA_RST;
            w2_r <= scc_pkg::DATA_RST;
            filt_r <= scc_pkg::DATA_RST;
            below_r <= 1'b0;
            above_r <= 1'b0;
            p_raw_r <= scc_pkg::DATA_RST;
            t_raw_r <= scc_pkg::DATA_RST;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            ppow_r <= ppow_nxt;
            tpow_r <= tpow_nxt;
            acc_r <= acc_nxt;
            data_r <= data_nxt;
            w1_r <= w1_nxt;
            w2_r <= w2_nxt;
            filt_r <= filt_nxt;
            below_r <= below_nxt;
            above_r <= above_nxt;
            p_raw_r <= p_raw_nxt;
            t_raw_r <= t_raw_nxt;
        end
    end

    // Output FIFO toward the DAC; a full FIFO holds the sequencer in push
    scc_fifo #(
        .WIDTH(scc_pkg::DAC_W),
        .DEPTH(scc_pkg::FIFO_DEPTH)
    ) u_dac_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(state_r == scc_pkg::ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(shifted[15:0]),
        .out_valid(dac_valid),
        .out_ready(dac_ready),
        .out_data(dac_code)
    );

    // Registered readback outputs
    assign compensated_result = data_r; // RULE5
    assign filtered_result = filt_r;
    assign below_normal = below_r;
    assign above_normal = above_r;

endmodule : scc_top

`default_nettype wire
